/* File: core/flash_status_regs.svh */
// constants, field positions and timing for the flash status and write-protect block
`ifndef FLASH_STATUS_REGS_SVH
`define FLASH_STATUS_REGS_SVH
`define FS_BIT_BUSY        0
`define FS_BIT_LATCH       1
`define FS_BIT_PROT_LO     2
`define FS_BIT_PROT_HI     4
`define FS_BIT_ZERO        5
`define FS_BIT_QUAD        6
`define FS_BIT_LOCK        7
`define FS_RESET_NV        8'h00
`define FS_OP_WRITE_STATUS 8'h01
`define FS_OP_PROGRAM      8'h02
`define FS_OP_READ_STATUS  8'h05
`define FS_OP_WRITE_ENABLE 8'h06
`define FS_OP_WRITE_DIS    8'h04
`define FS_OP_SECTOR_ERASE 8'h20
`define FS_OP_HALF_ERASE   8'h52
`define FS_OP_BLOCK_ERASE  8'hd8
`define FS_OP_CHIP_ERASE   8'hc7
`define FS_OP_CHIP_ERASE2  8'h60
`define FS_WRITE_TIME_NS   40000000
`define FS_ERASE_TIME_NS   1000000
`define FS_CLOCK_MHZ       200
`endif

/* File: core/flash_status_pkg.sv */
// types for the flash status and write-protect block
package flash_status_pkg;
  typedef enum logic [1:0] {
    cyc_idle,
    cyc_status,
    cyc_array
  } cycle_e;
endpackage

/* File: core/flash_protect_map.sv */
// configurable protect-level to address-range lookup
`timescale 1ns/1ps
module flash_protect_map #(
  parameter int          ADDR_W = 24,
  parameter logic [ADDR_W*8-1:0] LOW_BOUND = {ADDR_W*8{1'b0}}
)(
  input  wire logic [2:0]        level,
  input  wire logic [ADDR_W-1:0] addr,
  output logic                   hit
);
  logic [ADDR_W-1:0] bound;

  // level 0 protects nothing; others protect from table bound upward
  always_comb
  begin
    bound = LOW_BOUND[level*ADDR_W +: ADDR_W];
    hit   = (level != 3'd0) && (addr >= bound);
  end
endmodule // flash_protect_map

/* File: core/flash_status_wp.sv */
// status register, write-enable latch and write-protect logic of the serial flash
`timescale 1ns/1ps
`include "flash_status_regs.svh"
module flash_status_wp #(
  parameter int unsigned         ADDR_W       = 24,
  parameter int unsigned         WRITE_CYCLES = (`FS_WRITE_TIME_NS / 1000) * `FS_CLOCK_MHZ,
  parameter int unsigned         ERASE_CYCLES = (`FS_ERASE_TIME_NS / 1000) * `FS_CLOCK_MHZ,
  parameter logic [ADDR_W*8-1:0] PROT_BOUNDS  = {ADDR_W*8{1'b0}}
)(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              chip_select_n,
  input  wire logic              serial_clock,
  input  wire logic              serial_in_line,
  input  wire logic              write_guard_pin,
  output logic                   serial_out_line,
  output logic                   serial_out_oe_n,
  output logic [7:0]             status_word,
  output logic                   quad_mode,
  output logic                   hardware_lock_mode,
  output logic                   pause_enable,
  output logic                   array_write_go,
  output logic [7:0]             array_op,
  output logic [ADDR_W-1:0]      array_addr,
  output logic                   write_in_progress_flag
);
  logic [1:0]        cs_sync_r;
  logic [1:0]        sck_sync_r;
  logic [1:0]        si_sync_r;
  logic [1:0]        wp_sync_r;
  logic              sck_d_r;
  logic              cs_d_r;
  logic [7:0]        shift_r;
  logic [5:0]        bit_cnt_r;
  logic [7:0]        opcode_r;
  logic [7:0]        data_r;
  logic [ADDR_W-1:0] addr_r;
  logic              write_latch_flag_r;
  logic [2:0]        protect_level_bits_r;
  logic              quad_io_enable_r;
  logic              status_write_lock_r;
  logic [7:0]        new_status_r;
  logic [31:0]       cyc_cnt_r;
  logic [7:0]        out_shift_r;
  logic              out_oe_n_r;
  logic              array_go_r;
  logic [7:0]        array_op_r;
  logic [ADDR_W-1:0] array_addr_r;
  flash_status_pkg::cycle_e cycle_r;

  logic              sck_rise;
  logic              sck_fall;
  logic              cs_rise;
  logic              cs_low;
  logic              guard_low;
  logic              hw_lock;
  logic              busy;
  logic [7:0]        status_now;
  logic [7:0]        shift_in;
  logic              byte_done;
  logic              prot_hit;
  logic              is_array_op;
  logic              needs_addr;
  logic              frame_ok;

  // two-flop synchronisers for all pin inputs
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cs_sync_r  <= 2'h3;
      sck_sync_r <= 2'h0;
      si_sync_r  <= 2'h0;
      wp_sync_r  <= 2'h3;
      sck_d_r    <= 1'b0;
      cs_d_r     <= 1'b1;
    end
    else
    begin
      cs_sync_r  <= {cs_sync_r[0], chip_select_n};
      sck_sync_r <= {sck_sync_r[0], serial_clock};
      si_sync_r  <= {si_sync_r[0], serial_in_line};
      wp_sync_r  <= {wp_sync_r[0], write_guard_pin};
      sck_d_r    <= sck_sync_r[1];
      cs_d_r     <= cs_sync_r[1];
    end
  end

  assign cs_low    = !cs_sync_r[1];
  assign sck_rise  = cs_low && sck_sync_r[1] && !sck_d_r;
  assign sck_fall  = cs_low && !sck_sync_r[1] && sck_d_r;
  assign cs_rise   = cs_sync_r[1] && !cs_d_r;
  assign shift_in  = {shift_r[6:0], si_sync_r[1]};
  assign byte_done = sck_rise && (bit_cnt_r[2:0] == 3'd7);
  assign busy      = (cycle_r != flash_status_pkg::cyc_idle);
  // guard pin is ignored in quad mode; lock is pure level, so order does not matter
  assign guard_low = !wp_sync_r[1] && !quad_io_enable_r;
  assign hw_lock   = status_write_lock_r && guard_low;

  // status byte; bit 5 fixed zero
  always_comb
  begin
    status_now                                   = 8'h00;
    status_now[`FS_BIT_BUSY]                     = busy;
    status_now[`FS_BIT_LATCH]                    = write_latch_flag_r;
    status_now[`FS_BIT_PROT_HI:`FS_BIT_PROT_LO]  = protect_level_bits_r;
    status_now[`FS_BIT_QUAD]                     = quad_io_enable_r;
    status_now[`FS_BIT_LOCK]                     = status_write_lock_r;
  end

  // command shifter: opcode, then data or address bytes
  always_ff @(posedge clock)
  begin
    if (rst || !cs_low)
    begin
      shift_r   <= 8'h00;
      bit_cnt_r <= 6'd0;
      opcode_r  <= 8'h00;
      data_r    <= 8'h00;
      addr_r    <= '0;
    end
    else if (sck_rise)
    begin
      shift_r <= shift_in;
      if (bit_cnt_r != 6'd63)
        bit_cnt_r <= bit_cnt_r + 6'd1;
      if (byte_done && bit_cnt_r[5:3] == 3'd0)
        opcode_r <= shift_in;
      if (byte_done && bit_cnt_r[5:3] == 3'd1)
        data_r <= shift_in;
      if (byte_done && bit_cnt_r[5:3] >= 3'd1 && bit_cnt_r[5:3] <= 3'd3)
        addr_r <= {addr_r[ADDR_W-9:0], shift_in};
    end
  end

  flash_protect_map #(
    .ADDR_W    (ADDR_W),
    .LOW_BOUND (PROT_BOUNDS)
  ) u_map (
    .level (protect_level_bits_r),
    .addr  (addr_r),
    .hit   (prot_hit)
  );

  always_comb
  begin
    is_array_op = (opcode_r == `FS_OP_PROGRAM) || (opcode_r == `FS_OP_SECTOR_ERASE) ||
                  (opcode_r == `FS_OP_HALF_ERASE) || (opcode_r == `FS_OP_BLOCK_ERASE) ||
                  (opcode_r == `FS_OP_CHIP_ERASE) || (opcode_r == `FS_OP_CHIP_ERASE2);
    needs_addr  = (opcode_r != `FS_OP_CHIP_ERASE) && (opcode_r != `FS_OP_CHIP_ERASE2);
    // program must carry at least one data byte past the address; addressed erases must end exactly after it, chip erase right after the opcode
    if (!needs_addr)
      frame_ok = (bit_cnt_r == 6'd8);
    else if (opcode_r == `FS_OP_PROGRAM)
      frame_ok = (bit_cnt_r >= 6'd40) && (bit_cnt_r[2:0] == 3'd0);
    else
      frame_ok = (bit_cnt_r == 6'd32);
  end

  // write latch, non-volatile bits and self-timed cycles
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      write_latch_flag_r   <= 1'b0;
      protect_level_bits_r <= 3'h0;
      quad_io_enable_r     <= 1'b0;
      status_write_lock_r  <= 1'b0;
      new_status_r         <= `FS_RESET_NV;
      cyc_cnt_r            <= 32'h0;
      cycle_r              <= flash_status_pkg::cyc_idle;
      array_go_r           <= 1'b0;
      array_op_r           <= 8'h00;
      array_addr_r         <= '0;
    end
    else
    begin
      array_go_r <= 1'b0;
      case (cycle_r)
        flash_status_pkg::cyc_idle:
        begin
          if (cs_rise && bit_cnt_r == 6'd8 && opcode_r == `FS_OP_WRITE_ENABLE)
            write_latch_flag_r <= 1'b1;
          else if (cs_rise && bit_cnt_r == 6'd8 && opcode_r == `FS_OP_WRITE_DIS)
            write_latch_flag_r <= 1'b0;
          else if (cs_rise && opcode_r == `FS_OP_WRITE_STATUS && bit_cnt_r == 6'd16 &&
                   write_latch_flag_r && !hw_lock)
          begin
            new_status_r <= data_r;
            cyc_cnt_r    <= WRITE_CYCLES - 32'd1;
            cycle_r      <= flash_status_pkg::cyc_status;
          end
          else if (cs_rise && is_array_op && frame_ok && write_latch_flag_r)
          begin
            // protected targets are dropped; latch stays as it was
            if ((needs_addr && !prot_hit) || (!needs_addr && protect_level_bits_r == 3'h0))
            begin
              array_go_r   <= 1'b1;
              array_op_r   <= opcode_r;
              array_addr_r <= addr_r;
              cyc_cnt_r    <= ERASE_CYCLES - 32'd1;
              cycle_r      <= flash_status_pkg::cyc_array;
            end
          end
        end
        flash_status_pkg::cyc_status:
        begin
          if (cyc_cnt_r != 32'h0)
            cyc_cnt_r <= cyc_cnt_r - 32'd1;
          else
          begin
            // latch and busy bits of the written byte are discarded
            protect_level_bits_r <= new_status_r[`FS_BIT_PROT_HI:`FS_BIT_PROT_LO];
            quad_io_enable_r     <= new_status_r[`FS_BIT_QUAD];
            status_write_lock_r  <= new_status_r[`FS_BIT_LOCK];
            write_latch_flag_r   <= 1'b0;
            cycle_r              <= flash_status_pkg::cyc_idle;
          end
        end
        flash_status_pkg::cyc_array:
        begin
          if (cyc_cnt_r != 32'h0)
            cyc_cnt_r <= cyc_cnt_r - 32'd1;
          else
          begin
            write_latch_flag_r <= 1'b0;
            cycle_r            <= flash_status_pkg::cyc_idle;
          end
        end
        default:
          cycle_r <= flash_status_pkg::cyc_idle;
      endcase
    end
  end

  // status read: shift on falling serial clock, repeating for up to seven bytes while selected (bit count stops at 63)
  always_ff @(posedge clock)
  begin
    if (rst || !cs_low)
    begin
      out_shift_r <= 8'h00;
      out_oe_n_r  <= 1'b1;
    end
    else if (sck_fall && opcode_r == `FS_OP_READ_STATUS && bit_cnt_r >= 6'd8)
    begin
      out_oe_n_r <= 1'b0;
      if (bit_cnt_r[2:0] == 3'd0)
        out_shift_r <= status_now;
      else
        out_shift_r <= {out_shift_r[6:0], 1'b0};
    end
  end

  assign serial_out_line        = out_shift_r[7];
  assign serial_out_oe_n        = out_oe_n_r;
  assign status_word            = status_now;
  assign quad_mode              = quad_io_enable_r;
  assign hardware_lock_mode     = hw_lock;
  assign pause_enable           = !quad_io_enable_r;
  assign array_write_go         = array_go_r;
  assign array_op               = array_op_r;
  assign array_addr             = array_addr_r;
  assign write_in_progress_flag = busy;
endmodule // flash_status_wp

/* File: bench/flash_status_wp_asserts.sv */
// port checker for the flash status and write-protect block
`timescale 1ns/1ps
module flash_status_wp_asserts (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [7:0] status_word,
  input wire logic       quad_mode,
  input wire logic       hardware_lock_mode,
  input wire logic       pause_enable,
  input wire logic       array_write_go,
  input wire logic [7:0] array_op,
  input wire logic       write_in_progress_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_bit5_zero: assert property (status_word[5] == 1'b0) else $error("bit 5 not zero");
  a_busy_bit: assert property (status_word[0] == write_in_progress_flag) else $error("busy bit");
  a_quad_pause: assert property (pause_enable == !status_word[6] && quad_mode == status_word[6])
    else $error("quad outputs");
  a_hw_lock_cond: assert property (hardware_lock_mode |-> status_word[7] && !status_word[6])
    else $error("hw lock cause");
  a_hw_lock_frozen: assert property (hardware_lock_mode && $past(hardware_lock_mode) |->
    $stable(status_word[7:2])) else $error("bits moved under hw lock");
  a_nv_on_done: assert property ($changed(status_word[7:2]) |-> $fell(write_in_progress_flag))
    else $error("bits moved outside write");
  a_done_clears: assert property ($fell(write_in_progress_flag) |-> !status_word[1])
    else $error("latch kept");
  a_busy_latched: assert property ($rose(write_in_progress_flag) |-> $past(status_word[1]))
    else $error("busy without latch");
  a_busy_span: assert property ($rose(write_in_progress_flag) |-> write_in_progress_flag[*8])
    else $error("busy too short");
  a_erase_prot: assert property (array_write_go && array_op == 8'hc7 |-> status_word[4:2] == 3'h0)
    else $error("chip erase protected");
  cover property ($fell(write_in_progress_flag));
  cover property (hardware_lock_mode);
  cover property (array_write_go);
endmodule // flash_status_wp_asserts
bind flash_status_wp flash_status_wp_asserts i_flash_status_wp_asserts (.clock(clock), .rst(rst),
  .status_word(status_word), .quad_mode(quad_mode), .hardware_lock_mode(hardware_lock_mode),
  .pause_enable(pause_enable), .array_write_go(array_write_go), .array_op(array_op),
  .write_in_progress_flag(write_in_progress_flag));

/* File: bench/flash_host_model.sv */
// serial host model that frames commands
`timescale 1ns/1ps
module flash_host_model (
  input  wire logic clock,
  input  wire logic serial_out_line,
  output logic      chip_select_n,
  output logic      serial_clock,
  output logic      serial_in_line
);
  initial
  begin
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_in_line = 1'b0;
  end
  // mode 0, msb first, link clock parked low between frames
  // link edges kept off the system clock's rising edge; q gathers read data on each rise
  task automatic frame(input int n, input logic [39:0] d, output logic [7:0] q);
    @(posedge clock);
    #1 chip_select_n = 1'b0;
    #0.5;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in_line = d[i];
      #24 serial_clock = 1'b1;
      q = {q[6:0], serial_out_line};
      #24 serial_clock = 1'b0;
    end
    #24 chip_select_n = 1'b1;
    serial_in_line = ~serial_in_line;
    repeat (6) @(posedge clock);
    #1;
  endtask
endmodule // flash_host_model

/* File: bench/flash_status_wp_test.sv */
// self-checking bench for the flash status and write-protect block
`timescale 1ns/1ps
module flash_status_wp_test;
  logic       clock, rst, guard, cs_n, sck, sdi, sdo;
  logic [7:0] status_word, array_op, m, d, rq;
  logic       quad_mode, hw_lock, pause_enable, go, busy;
  int         errors, n_checks, gos;
  flash_status_wp #(.WRITE_CYCLES(200), .ERASE_CYCLES(20)) i_flash_status_wp (.clock(clock), .rst(rst),
    .chip_select_n(cs_n), .serial_clock(sck), .serial_in_line(sdi), .write_guard_pin(guard),
    .serial_out_line(sdo), .serial_out_oe_n(), .status_word(status_word), .quad_mode(quad_mode),
    .hardware_lock_mode(hw_lock), .pause_enable(pause_enable), .array_write_go(go),
    .array_op(array_op), .array_addr(), .write_in_progress_flag(busy));
  flash_host_model i_flash_host_model (.clock(clock), .serial_out_line(sdo), .chip_select_n(cs_n),
    .serial_clock(sck), .serial_in_line(sdi));
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock)
    if (go === 1'b1 && array_op === 8'hc7)
      gos++;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // frame, check busy just after it, then poll until idle
  task automatic op(input int n, input logic [39:0] v, input logic b);
    int k;
    k = 0;
    i_flash_host_model.frame(n, v, rq);
    chk({7'h0, busy}, {7'h0, b});
    while (busy !== 1'b0 && k < 500)
    begin
      @(posedge clock);
      k++;
    end
    #1;
    chk({7'h0, k < 500}, 8'h01);
  endtask
  task automatic settle;
    repeat (6) @(posedge clock);
    #1;
  endtask
  initial
  begin
    errors = 0;
    n_checks = 0;
    gos = 0;
    void'($urandom(32'h251da7ee));
    rst = 1'b1;
    guard = 1'b1;
    repeat (3) @(posedge clock);
    #1 rst = 1'b0;
    settle();
    m = 8'h00;
    chk(status_word, m);
    op(8, 'h06, 0);
    chk(status_word, m | 8'h02);
    i_flash_host_model.frame(16, 'h01bf, rq);
    op(16, 'h0500, 1);
    chk(rq, 8'h03);
    m = 8'h9c;
    chk(status_word, m);
    guard = 1'b0;
    settle();
    chk({7'h0, hw_lock}, 8'h01);
    op(8, 'h06, 0);
    op(16, 'h0100, 0);
    chk(status_word, m | 8'h02);
    guard = 1'b1;
    settle();
    chk({7'h0, hw_lock}, 8'h00);
    op(16, 'h0100, 1);
    guard = 1'b0;
    op(8, 'h06, 0);
    op(16, 'h0180, 1);
    settle();
    chk({hw_lock, status_word[6:0]}, 8'h80);
    guard = 1'b1;
    op(8, 'h06, 0);
    op(16, 'h0100, 1);
    repeat (3)
    begin
      d = $urandom;
      op(8, 'h06, 0);
      op(16, {8'h01, d}, 1);
      chk(status_word, d & 8'hdc);
    end
    op(8, 'h06, 0);
    op(16, 'h0100, 1);
    op(8, 'h06, 0);
    op(15, 'h00ff, 0);
    chk(status_word, 8'h02);
    op(8, 'h04, 0);
    op(16, 'h011c, 0);
    chk(status_word, 8'h00);
    op(8, 'h06, 0);
    op(16, 'h0104, 1);
    op(8, 'h06, 0);
    op(8, 'hc7, 0);
    chk(gos[7:0], 8'h00);
    op(16, 'h0100, 1);
    op(8, 'h06, 0);
    op(8, 'hc7, 1);
    chk({gos[3:0], status_word[3:0]}, 8'h10);
    op(8, 'h06, 0);
    op(16, 'h01c0, 1);
    guard = 1'b0;
    settle();
    chk({quad_mode, pause_enable, hw_lock, status_word[4:0]}, 8'h80);
    close_out();
  end
  initial
  begin
    #200000;
    errors++;
    close_out();
  end
endmodule // flash_status_wp_test
